// [core/epic_regs.svh]
`ifndef EPIC_REGS_SVH
`define EPIC_REGS_SVH

// ----------------------------------------------------------------
// Register byte offsets on the Wishbone bus
// ----------------------------------------------------------------
`define EPIC_OFS_SENSE 8'h00
`define EPIC_OFS_ENABLE 8'h04
`define EPIC_OFS_FLAG 8'h08
`define EPIC_OFS_GIE 8'h0C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define EPIC_SENSE1_BIT_HI 3
`define EPIC_SENSE1_BIT_LO 2
`define EPIC_SENSE0_BIT_HI 1
`define EPIC_SENSE0_BIT_LO 0
`define EPIC_EN1_BIT 7
`define EPIC_EN0_BIT 6
`define EPIC_VSEL_BIT 1
`define EPIC_VUNLOCK_BIT 0
`define EPIC_FLAG1_BIT 7
`define EPIC_FLAG0_BIT 6
`define EPIC_GIE_BIT 7

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define EPIC_SENSE_RST 8'h00
`define EPIC_ENABLE_RST 8'h00
`define EPIC_FLAG_RST 2'h0
`define EPIC_GIE_RST 1'h0
`define EPIC_SYNC_RST 2'h3

`endif

// [core/epic_pkg.sv]
package epic_pkg;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------

    // Sense encodings, two bits per pin
    typedef enum logic [1:0] {
        EPIC_SENSE_LOW = 2'h0,
        EPIC_SENSE_ANY = 2'h1,
        EPIC_SENSE_FALL = 2'h2,
        EPIC_SENSE_RISE = 2'h3
    } epic_sense_t;

    // One Wishbone request as seen by the slave
    typedef struct packed {
        logic [7:0] adr;
        logic [31:0] dat;
        logic [3:0] sel;
        logic we;
    } epic_wb_req_t;

    // Edge or toggle event from the current and previous sample
    function automatic logic epic_event(input epic_sense_t mode, input logic cur, input logic prev);
        logic hit;
        hit = 1'b0;
        unique case (mode)
            EPIC_SENSE_LOW: hit = 1'b0;
            EPIC_SENSE_ANY: hit = cur ^ prev;
            EPIC_SENSE_FALL: hit = prev & ~cur;
            EPIC_SENSE_RISE: hit = cur & ~prev;
        endcase
        return hit;
    endfunction

endpackage

// [core/epic_sync.sv]
`timescale 1ns/1ps
`include "epic_regs.svh"

module epic_sync (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Asynchronous pins in, synchronised levels out
    input wire logic [1:0] pin_i,
    output logic [1:0] sync_o
);

    // First stage, read only by the second stage
    logic [1:0] stage1_reg;
    // Second stage, safe for the logic
    logic [1:0] stage2_reg;

    // ----------------------------------------------------------------
    // Two flip-flop synchroniser, idle level high
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stage1_reg <= `EPIC_SYNC_RST;
            stage2_reg <= `EPIC_SYNC_RST;
        end else begin
            stage1_reg <= pin_i;
            stage2_reg <= stage1_reg;
        end
    end

    assign sync_o = stage2_reg;

endmodule

// [core/epic_sense_det.sv]
`timescale 1ns/1ps

module epic_sense_det
    import epic_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Synchronised pin level and its sense setting
    input wire logic level_i,
    input wire epic_sense_t mode_i,
    // Edge event pulse and low-level request
    output logic event_o,
    output logic low_o
);

    // Previous sample, idle level high after reset
    logic prev_reg;

    // ----------------------------------------------------------------
    // Previous sample for edge comparison
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_reg <= 1'b1;
        end else begin
            prev_reg <= level_i;
        end
    end

    // Edge and toggle decode on sampled values
    assign event_o = epic_event(mode_i, level_i, prev_reg);
    // Level request while low in low-level mode
    assign low_o = (mode_i == EPIC_SENSE_LOW) & ~level_i;

endmodule

// [core/epic_top.sv]
`timescale 1ns/1ps
`include "epic_regs.svh"

// How it works
// [R1] Pin 1 sense bits 3:2 select mode
// [R2] Pin 0 sense bits 1:0 select mode
// [R3] Pin sampled first; long pulses always seen
// [R4] Source holds low level until instruction ends
// [R5] Forward only with global and pin enable
// [R6] Enable bits 7,6; bits 5:2 read zero
// [R7] Pin activity requests even when driven internally
// [R8] Each pin has its own vector
// [R9] Pin event sets flag bit 7 or 6
// [R10] Servicing the vector clears its flag
// [R11] Writing one clears flag; zero keeps it
// [R12] Flag reads cleared in low-level mode
// [R13] Low level requests while pin stays low
// [R14] Edges need clock; low level wakes asynchronously
// [R15] Two-stage synchroniser then compare with previous
module epic_top
    import epic_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // External interrupt pins
    input wire logic ext_irq_pin_0_i,
    input wire logic ext_irq_pin_1_i,
    // Interrupt dispatch to the CPU
    output logic irq_o,
    output logic irq_vec_o,
    output logic vec_table_sel_o,
    input wire logic irq_ack_i,
    input wire logic irq_ack_vec_i,
    // Asynchronous wake request
    output logic wake_o
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------

    // Bus request gathered into one carrier
    epic_wb_req_t wb_req;
    // New request not yet answered
    logic wb_hit;
    // Write taking effect at this edge
    logic wb_wr;
    // Acknowledge flip-flop
    logic ack_reg;
    // Registered read data
    logic [31:0] rdat_reg;
    // Read data for the addressed register
    logic [7:0] rdat_next;

    // Sense control, all eight bits stored
    logic [7:0] sense_control_reg;
    // Pin enables, index 0 is pin 0
    logic [1:0] pin_en_reg;
    // Vector table select and change unlock bits
    logic vsel_reg;
    logic vunlock_reg;
    // Pin event flags, index 0 is pin 0
    logic [1:0] flag_reg;
    // Global interrupt enable
    logic gie_reg;

    // Raw pins and their synchronised copies
    logic [1:0] pin_raw;
    logic [1:0] pin_sync;
    // Sense mode per pin
    epic_sense_t mode [2];
    // Low-level mode per pin
    logic [1:0] low_mode;
    // Edge events and low requests per pin
    logic [1:0] pin_event;
    logic [1:0] low_req;
    // Flag clear sources
    logic [1:0] flag_w1c;
    logic [1:0] svc_clr;
    // Requests, enabled requests, forwarded requests
    logic [1:0] req;
    logic [1:0] pend;
    logic [1:0] take;
    // Registered dispatch outputs
    logic irq_reg;
    logic irq_vec_reg;
    // Flag register readback byte
    logic [7:0] flag_byte;

    // ----------------------------------------------------------------
    // Pin sampling
    // ----------------------------------------------------------------

    // The pad level is used, so a pin driven by the device still counts
    // [R7] Pad level used
    assign pin_raw = {ext_irq_pin_1_i, ext_irq_pin_0_i};

    // Pins pass two flip-flops before the sense decode; only wake_o reads them raw
    epic_sync u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(pin_raw),
        .sync_o(pin_sync)
    );

    // Sense bit decode, pin 0 then pin 1
    // [R2] Pin 0 mode
    assign mode[0] = epic_sense_t'(sense_control_reg[`EPIC_SENSE0_BIT_HI:`EPIC_SENSE0_BIT_LO]);
    // [R1] Pin 1 mode
    assign mode[1] = epic_sense_t'(sense_control_reg[`EPIC_SENSE1_BIT_HI:`EPIC_SENSE1_BIT_LO]);

    // One edge detector per pin
    for (genvar p = 0; p < 2; p++) begin : g_det
        // Low-level mode flag for this pin
        assign low_mode[p] = (mode[p] == EPIC_SENSE_LOW);
        // [R15] [R3] Sampled compare
        epic_sense_det u_det (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .level_i(pin_sync[p]),
            .mode_i(mode[p]),
            .event_o(pin_event[p]),
            .low_o(low_req[p])
        );
    end

    // ----------------------------------------------------------------
    // Wishbone slave
    // ----------------------------------------------------------------

    // Request carrier
    assign wb_req = '{adr: wb_adr_i, dat: wb_dat_i, sel: wb_sel_i, we: wb_we_i};
    // A fresh strobe is answered one cycle later
    assign wb_hit = wb_cyc_i & wb_stb_i & ~ack_reg;
    // Writes land at the edge where the master sees ack, low lane only
    assign wb_wr = wb_cyc_i & wb_stb_i & ack_reg & wb_req.we & wb_req.sel[0];

    // Acknowledge, dropped in the cycle after it was given
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= wb_hit;
        end
    end

    // Flag readback, masked while in low-level mode
    // [R12] Low mode reads cleared
    assign flag_byte = {flag_reg[1] & ~low_mode[1], flag_reg[0] & ~low_mode[0], 6'h00};

    // Read multiplexer, unmapped offsets read zero
    always_comb begin
        rdat_next = 8'h00;
        unique case (wb_req.adr)
            `EPIC_OFS_SENSE: rdat_next = sense_control_reg;
            // [R6] Bits 5:2 read zero
            `EPIC_OFS_ENABLE: rdat_next = {pin_en_reg[1], pin_en_reg[0], 4'h0, vsel_reg, vunlock_reg};
            `EPIC_OFS_FLAG: rdat_next = flag_byte;
            `EPIC_OFS_GIE: rdat_next = {gie_reg, 7'h00};
            default: rdat_next = 8'h00;
        endcase
    end

    // Read data captured with the acknowledge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_reg <= 32'h00000000;
        end else if (wb_hit) begin
            rdat_reg <= {24'h000000, rdat_next};
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdat_reg;

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------

    // Sense control, plain read-write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sense_control_reg <= `EPIC_SENSE_RST;
        end else if (wb_wr && wb_req.adr == `EPIC_OFS_SENSE) begin
            sense_control_reg <= wb_req.dat[7:0];
        end
    end

    // Enable register, only bits 7, 6, 1 and 0 are stored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_en_reg <= 2'h0;
            vsel_reg <= 1'b0;
            vunlock_reg <= 1'b0;
        end else if (wb_wr && wb_req.adr == `EPIC_OFS_ENABLE) begin
            // [R6] Enable bit layout
            pin_en_reg <= {wb_req.dat[`EPIC_EN1_BIT], wb_req.dat[`EPIC_EN0_BIT]};
            vsel_reg <= wb_req.dat[`EPIC_VSEL_BIT];
            vunlock_reg <= wb_req.dat[`EPIC_VUNLOCK_BIT];
        end
    end

    // Global interrupt enable
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gie_reg <= `EPIC_GIE_RST;
        end else if (wb_wr && wb_req.adr == `EPIC_OFS_GIE) begin
            gie_reg <= wb_req.dat[`EPIC_GIE_BIT];
        end
    end

    // ----------------------------------------------------------------
    // Event flags
    // ----------------------------------------------------------------

    // [R11] Write one to clear
    assign flag_w1c = (wb_wr && wb_req.adr == `EPIC_OFS_FLAG) ?
        {wb_req.dat[`EPIC_FLAG1_BIT], wb_req.dat[`EPIC_FLAG0_BIT]} : 2'h0;
    // [R10] Service clears flag
    assign svc_clr = irq_ack_i ? {irq_ack_vec_i, ~irq_ack_vec_i} : 2'h0;

    // Sticky flags; a new event wins over any clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_reg <= `EPIC_FLAG_RST;
        end else begin
            for (int p = 0; p < 2; p++) begin
                if (low_mode[p]) begin
                    // [R12] Held cleared
                    flag_reg[p] <= 1'b0;
                end else if (pin_event[p]) begin
                    // [R9] Event sets flag
                    flag_reg[p] <= 1'b1;
                end else if (flag_w1c[p] || svc_clr[p]) begin
                    flag_reg[p] <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Request gating and dispatch
    // ----------------------------------------------------------------

    // [R13] Level carries request
    assign req = (low_mode & low_req) | (~low_mode & flag_reg);
    // Pin enables act as the mask
    assign pend = req & pin_en_reg;
    // [R5] Global enable gate
    assign take = pend & {2{gie_reg}};

    // Registered level interrupt and vector, pin 0 first
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_reg <= 1'b0;
            irq_vec_reg <= 1'b0;
        end else begin
            irq_reg <= |take;
            // [R8] Own vector per pin
            irq_vec_reg <= ~take[0] & take[1];
        end
    end

    assign irq_o = irq_reg;
    assign irq_vec_o = irq_vec_reg;
    assign vec_table_sel_o = vsel_reg;

    // [R14] Asynchronous low-level wake
    assign wake_o = |(low_mode & pin_en_reg & ~pin_raw);

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // Synchronised levels one cycle back, for checking only
    logic [1:0] sync_d;
    always_ff @(posedge clk_i) begin
        sync_d <= pin_sync;
    end

    AST_PIN1_DECODE: assert property ( // [R1]
        $rose(flag_reg[1]) |-> $past(
            (sense_control_reg[`EPIC_SENSE1_BIT_HI:`EPIC_SENSE1_BIT_LO] == 2'h1 && pin_sync[1] != sync_d[1])
            || (sense_control_reg[`EPIC_SENSE1_BIT_HI:`EPIC_SENSE1_BIT_LO] == 2'h2 && sync_d[1] && !pin_sync[1])
            || (sense_control_reg[`EPIC_SENSE1_BIT_HI:`EPIC_SENSE1_BIT_LO] == 2'h3 && pin_sync[1] && !sync_d[1])))
        else $error("pin 1 flag set without decoded event");

    AST_PIN0_DECODE: assert property ( // [R2]
        $rose(flag_reg[0]) |-> $past(
            (sense_control_reg[`EPIC_SENSE0_BIT_HI:`EPIC_SENSE0_BIT_LO] == 2'h1 && pin_sync[0] != sync_d[0])
            || (sense_control_reg[`EPIC_SENSE0_BIT_HI:`EPIC_SENSE0_BIT_LO] == 2'h2 && sync_d[0] && !pin_sync[0])
            || (sense_control_reg[`EPIC_SENSE0_BIT_HI:`EPIC_SENSE0_BIT_LO] == 2'h3 && pin_sync[0] && !sync_d[0])))
        else $error("pin 0 flag set without decoded event");

    AST_RISE_CAUGHT: assert property ( // [R3]
        (mode[0] == EPIC_SENSE_RISE && $rose(pin_sync[0]) && !$past(rst_i)) |=> flag_reg[0])
        else $error("rising edge on pin 0 not flagged");

    AST_GLOBAL_GATE: assert property ( // [R5]
        irq_reg |-> $past(gie_reg) && $past(|pend))
        else $error("interrupt raised without both enables");

    AST_EN_READ_ZERO: assert property ( // [R6]
        (wb_ack_o && !wb_we_i && wb_adr_i == `EPIC_OFS_ENABLE) |-> wb_dat_o[5:2] == 4'h0 && wb_dat_o[31:8] == 24'h0)
        else $error("enable register reserved bits not zero");

    AST_VECTOR_SEL: assert property ( // [R8]
        (take == 2'h2) |=> irq_o && irq_vec_o)
        else $error("pin 1 request not on its vector");

    AST_W1C_CLEAR: assert property ( // [R11]
        (flag_w1c[0] && !pin_event[0]) |=> !flag_reg[0])
        else $error("write one did not clear pin 0 flag");

    AST_SVC_CLEAR: assert property ( // [R10]
        (svc_clr[1] && !pin_event[1]) |=> !flag_reg[1])
        else $error("service did not clear pin 1 flag");

    AST_LOW_NO_FLAG: assert property ( // [R12]
        $past(low_mode[0]) |-> !flag_reg[0] && !flag_byte[`EPIC_FLAG0_BIT])
        else $error("pin 0 flag set in low-level mode");

    AST_LOW_HOLD: assert property ( // [R13]
        (low_mode[0] && pin_en_reg[0] && gie_reg && !pin_sync[0])[*3] |=> irq_o && !irq_vec_o)
        else $error("held low level not requesting");

    AST_EDGE_NO_WAKE: assert property ( // [R14]
        (!low_mode[0] && !low_mode[1]) |-> !wake_o)
        else $error("wake raised outside low-level mode");

    AST_SYNC_DELAY: assert property ( // [R15]
        (mode[0] == EPIC_SENSE_RISE && $past(mode[0]) == EPIC_SENSE_RISE && $rose(flag_reg[0]))
        |-> $past(ext_irq_pin_0_i, 3) && !$past(ext_irq_pin_0_i, 4))
        else $error("pin 0 edge not two samples late");

    COV_EDGE_IRQ: cover property (!low_mode[0] && $rose(flag_reg[0]) ##[1:4] irq_o);
    COV_LEVEL_IRQ: cover property (low_mode[1] && take[1] ##1 irq_o && irq_vec_o);
    COV_SERVICE: cover property (irq_o ##[1:8] svc_clr[0] ##1 !flag_reg[0]);
    COV_W1C: cover property (flag_reg[1] && flag_w1c[1]);

endmodule

// [dv/epic_pin_src.sv]
`timescale 1ns/1ps

module epic_pin_src (
    // Clock
    input wire logic clk_i,
    // Pads towards the block
    output logic ext_irq_pin_0_o,
    output logic ext_irq_pin_1_o
);
    // ----------------------------------------------------------------
    // Pad state
    // ----------------------------------------------------------------
    // Idle high, as a pulled-up interrupt line would sit
    logic [1:0] pad_reg = 2'h3;

    assign ext_irq_pin_0_o = pad_reg[0];
    assign ext_irq_pin_1_o = pad_reg[1];

    // ----------------------------------------------------------------
    // Drive tasks
    // ----------------------------------------------------------------
    // Level held on
    // Level stays until the caller changes it, so a low request persists
    task automatic set_pad(input int p, input logic lvl);
        @(posedge clk_i);
        pad_reg[p] <= lvl;
    endtask

    // Pulse over one
    // Inverted pulse lasting the given number of clocks, then back
    task automatic pulse_pad(input int p, input int cycles);
        set_pad(p, ~pad_reg[p]);
        repeat (cycles) @(posedge clk_i);
        pad_reg[p] <= ~pad_reg[p];
    endtask
endmodule

// [dv/tb_top.sv]
`timescale 1ns/1ps
`include "epic_regs.svh"

module tb_top;
    import epic_pkg::*;

    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic pin0;
    logic pin1;
    logic irq_o;
    logic irq_vec_o;
    logic vec_table_sel_o;
    logic irq_ack_i = 1'b0;
    logic irq_ack_vec_i = 1'b0;
    logic wake_o;
    int error_cnt = 0;
    int tests_run = 0;

    always #20 clk_i = ~clk_i;

    epic_top u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_irq_pin_0_i(pin0),
        .ext_irq_pin_1_i(pin1), .irq_o(irq_o), .irq_vec_o(irq_vec_o),
        .vec_table_sel_o(vec_table_sel_o), .irq_ack_i(irq_ack_i),
        .irq_ack_vec_i(irq_ack_vec_i), .wake_o(wake_o)
    );

    epic_pin_src u_src (
        .clk_i(clk_i),
        .ext_irq_pin_0_o(pin0),
        .ext_irq_pin_1_o(pin1)
    );

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic tally_and_finish();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // One classic cycle; request held until ack is sampled high
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                           output logic [31:0] rd);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        for (n = 0; n < 20; n++) begin
            @(posedge clk_i);
            if (wb_ack_o === 1'b1) break;
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        // Bus hang ends the run
        if (n == 20) begin
            error_cnt++;
            tally_and_finish();
        end
    endtask

    task automatic wb_wr(input logic [7:0] adr, input logic [31:0] wd);
        logic [31:0] rd;
        wb_xfer(1'b1, adr, wd, rd);
    endtask

    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] rd;
        wb_xfer(1'b0, adr, 32'h0, rd);
        check(rd, exp);
    endtask

    // CPU takes one vector for a single clock
    task automatic service(input logic v);
        @(posedge clk_i);
        irq_ack_i <= 1'b1;
        irq_ack_vec_i <= v;
        @(posedge clk_i);
        irq_ack_i <= 1'b0;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        rd_chk(`EPIC_OFS_SENSE, 32'h0);
        rd_chk(`EPIC_OFS_ENABLE, 32'h0);
        rd_chk(`EPIC_OFS_FLAG, 32'h0);
        rd_chk(`EPIC_OFS_GIE, 32'h0);
        rd_chk(8'h10, 32'h0);
        check({31'h0, irq_o}, 32'h0);
    endtask

    task automatic t_enable();
        wb_wr(`EPIC_OFS_ENABLE, 32'hFF);
        rd_chk(`EPIC_OFS_ENABLE, 32'hC3);
        check({31'h0, vec_table_sel_o}, 32'h1);
        wb_wr(`EPIC_OFS_ENABLE, 32'h00);
    endtask

    // Move pad p to to_lvl in mode m and compare the flag it leaves
    task automatic try_edge(input int p, input epic_sense_t m, input logic to_lvl, input logic exp);
        u_src.set_pad(p, ~to_lvl);
        wait_cyc(4);
        wb_wr(`EPIC_OFS_SENSE, {28'h0, m, m});
        wb_wr(`EPIC_OFS_FLAG, 32'hC0);
        u_src.set_pad(p, to_lvl);
        wait_cyc(4);
        rd_chk(`EPIC_OFS_FLAG, exp ? (32'h40 << p) : 32'h0);
    endtask

    task automatic t_edges();
        for (int p = 0; p < 2; p++) begin
            try_edge(p, EPIC_SENSE_ANY, 1'b1, 1'b1);
            try_edge(p, EPIC_SENSE_ANY, 1'b0, 1'b1);
            try_edge(p, EPIC_SENSE_FALL, 1'b1, 1'b0);
            try_edge(p, EPIC_SENSE_FALL, 1'b0, 1'b1);
            try_edge(p, EPIC_SENSE_RISE, 1'b0, 1'b0);
            try_edge(p, EPIC_SENSE_RISE, 1'b1, 1'b1);
        end
        // Two-clock low pulse on pad 1 in falling mode
        wb_wr(`EPIC_OFS_SENSE, 32'h0A);
        wb_wr(`EPIC_OFS_FLAG, 32'hC0);
        u_src.pulse_pad(1, 2);
        wait_cyc(4);
        rd_chk(`EPIC_OFS_FLAG, 32'h80);
    endtask

    task automatic t_irq();
        wb_wr(`EPIC_OFS_SENSE, 32'h0F);
        u_src.set_pad(0, 1'b0);
        u_src.set_pad(1, 1'b0);
        wait_cyc(4);
        wb_wr(`EPIC_OFS_FLAG, 32'hC0);
        wb_wr(`EPIC_OFS_ENABLE, 32'hC0);
        u_src.set_pad(0, 1'b1);
        u_src.set_pad(1, 1'b1);
        wait_cyc(4);
        check({31'h0, irq_o}, 32'h0);
        wb_wr(`EPIC_OFS_FLAG, 32'h00);
        rd_chk(`EPIC_OFS_FLAG, 32'hC0);
        wb_wr(`EPIC_OFS_GIE, 32'h80);
        wait_cyc(2);
        check({30'h0, irq_vec_o, irq_o}, 32'h1);
        wb_wr(`EPIC_OFS_ENABLE, 32'h80);
        wait_cyc(2);
        check({30'h0, irq_vec_o, irq_o}, 32'h3);
        wb_wr(`EPIC_OFS_ENABLE, 32'hC0);
        service(1'b0);
        wait_cyc(3);
        rd_chk(`EPIC_OFS_FLAG, 32'h80);
        check({30'h0, irq_vec_o, irq_o}, 32'h3);
        wb_wr(`EPIC_OFS_FLAG, 32'h80);
        rd_chk(`EPIC_OFS_FLAG, 32'h0);
        wait_cyc(2);
        check({31'h0, irq_o}, 32'h0);
        // Fresh pin 1 event, cleared by servicing its own vector
        u_src.pulse_pad(1, 2);
        wait_cyc(4);
        service(1'b1);
        wait_cyc(3);
        rd_chk(`EPIC_OFS_FLAG, 32'h0);
        check({31'h0, irq_o}, 32'h0);
    endtask

    task automatic t_level();
        wb_wr(`EPIC_OFS_SENSE, 32'h00);
        wb_wr(`EPIC_OFS_ENABLE, 32'h40);
        u_src.set_pad(0, 1'b0);
        wait_cyc(4);
        check({30'h0, wake_o, irq_o}, 32'h3);
        rd_chk(`EPIC_OFS_FLAG, 32'h0);
        service(1'b0);
        wait_cyc(8);
        check({31'h0, irq_o}, 32'h1);
        u_src.set_pad(0, 1'b1);
        wait_cyc(4);
        check({30'h0, wake_o, irq_o}, 32'h0);
        // Pin 1 held low on its own vector
        wb_wr(`EPIC_OFS_ENABLE, 32'h80);
        u_src.set_pad(1, 1'b0);
        wait_cyc(4);
        check({29'h0, wake_o, irq_vec_o, irq_o}, 32'h7);
        u_src.set_pad(1, 1'b1);
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        wait_cyc(5);
        rst_i <= 1'b0;
        wait_cyc(2);
        t_reset();
        t_enable();
        t_edges();
        t_irq();
        t_level();
        tally_and_finish();
    end
endmodule
